/* core/status_regs_pkg.sv */
package status_regs_pkg;
	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 32;
	localparam logic [7:0]  OFS_ALGORITHM_STATUS_WORD   = 8'hE4;
	localparam logic [7:0]  OFS_MOTOR_PARAMS  = 8'hE6;
	localparam logic [7:0]  OFS_MEAS_STATUS   = 8'hE8;
	localparam logic [7:0]  OFS_DEVICE_CTRL   = 8'hEA;
	localparam logic [31:0] RESET_VALUE       = 32'h00000000;
	localparam int          MOD_INDEX_LSB     = 16;
	localparam int          DUTY_CMD_LSB      = 4;
	localparam int          HOST_READY_BIT    = 2;
	localparam int          RESISTANCE_LSB    = 24;
	localparam int          EMF_CONST_LSB     = 16;
	localparam int          INDUCTANCE_LSB    = 8;
	localparam int          R_STATUS_BIT      = 31;
	localparam int          L_STATUS_BIT      = 30;
	localparam int          KE_STATUS_BIT     = 29;
	localparam int          MECH_STATUS_BIT   = 28;
	localparam int          SWITCH_FREQ_LSB   = 24;
	localparam int          MOD_INDEX_FULL    = 32768;
	localparam int          DUTY_CMD_FULL     = 4096;
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_ALGO,
		SEL_MOTOR,
		SEL_MEAS
	} reg_sel_t;
endpackage : status_regs_pkg

/* core/status_bus_if.sv */
interface status_bus_if;
	import status_regs_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic              rd_en;
	logic              wr_en;
	reg_sel_t          sel;
	logic              hit;
	modport decoder (input addr, input rd_en, input wr_en, output sel, output hit);
	modport bank    (output addr, output rd_en, output wr_en, input sel, input hit);
endinterface : status_bus_if

/* core/status_addr_decode.sv */
module status_addr_decode (
	status_bus_if.decoder bus // address in, select out
);
	import status_regs_pkg::*;
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_ALGORITHM_STATUS_WORD:  decode = SEL_ALGO;
			OFS_MOTOR_PARAMS: decode = SEL_MOTOR;
			OFS_MEAS_STATUS:  decode = SEL_MEAS;
			default:          decode = SEL_NONE;
		endcase
	endfunction : decode
	assign bus.sel = decode(bus.addr);
	assign bus.hit = (bus.sel != SEL_NONE) && bus.rd_en;
endmodule : status_addr_decode

/* core/motor_algorithm_status_word_registers.sv */
// Notes on behaviour
// RQ1: modulation index, unsigned 16 bits, in status word bits 31..16, full scale 32768.
// RQ2: decoded duty command, 12 bits, in bits 15..4, full scale 4096.
// RQ3: bit 2 low while defaults copy from shadow memory, high when host may control.
// RQ4: measured resistance in motor parameters bits 31..24.
// RQ5: measured back-emf constant in motor parameters bits 23..16.
// RQ6: measured inductance in bits 15..8; bits 7..0 read zero.
// RQ7: measurement status bits: resistance 31, inductance 30, emf constant 29, mechanical 28.
// RQ8: recommended switching frequency code in bits 27..24; bits 23..0 read zero.
// RQ9: all three status registers read-only and reset to zero.
// RQ10: host leaves unlisted offsets alone.
// RQ11: writes to status registers change nothing and have no side effect.
module motor_algorithm_status_word_registers (
	input  wire logic                                 clock,                  // 25 MHz system clock
	input  wire logic                                 reset_n,                // async reset, active low
	input  wire logic [status_regs_pkg::ADDR_W-1:0]   reg_addr,               // register offset
	input  wire logic                                 reg_rd_en,              // read strobe
	input  wire logic                                 reg_wr_en,              // write strobe
	input  wire logic [status_regs_pkg::DATA_W-1:0]   reg_wr_data,            // write data, unused
	output logic      [status_regs_pkg::DATA_W-1:0]   reg_rd_data,            // read data
	output logic                                      reg_rd_valid,           // read answer pulse
	input  wire logic [15:0]                          modulation_index,       // applied modulation index
	input  wire logic [11:0]                          duty_command,           // decoded speed duty
	input  wire logic                                 shadow_copy_done,       // defaults copied
	input  wire logic                                 param_update,           // load measured values
	input  wire logic [7:0]                           motor_resistance,       // measured resistance
	input  wire logic [7:0]                           back_emf_constant,      // measured emf constant
	input  wire logic [7:0]                           motor_inductance,       // measured inductance
	input  wire logic                                 resistance_meas_status, // resistance status
	input  wire logic                                 inductance_meas_status, // inductance status
	input  wire logic                                 emf_const_meas_status,  // emf constant status
	input  wire logic                                 mechanical_meas_status, // mechanical status
	input  wire logic [3:0]                           recommended_switch_freq // switching freq code
);
	import status_regs_pkg::*;

	status_bus_if bus ();

	logic [DATA_W-1:0] algo_q;
	logic [DATA_W-1:0] algo_d;
	logic [DATA_W-1:0] motor_q;
	logic [DATA_W-1:0] motor_d;
	logic [DATA_W-1:0] meas_q;
	logic [DATA_W-1:0] meas_d;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic              rd_valid_q;
	logic              ready_q;
	logic [DATA_W-1:0] rd_mux;

	assign bus.addr  = reg_addr;
	assign bus.rd_en = reg_rd_en;
	assign bus.wr_en = reg_wr_en;

	status_addr_decode u_decode (
		.bus (bus)
	);

	// ready flag goes high once defaults are in and stays high until reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ready_q <= 1'b0;
		else if (shadow_copy_done)
			ready_q <= 1'b1; // [RQ3]
	end

	always_comb begin
		algo_d = RESET_VALUE;
		algo_d[MOD_INDEX_LSB +: 16] = modulation_index; // [RQ1]
		algo_d[DUTY_CMD_LSB +: 12]  = duty_command;     // [RQ2]
		algo_d[HOST_READY_BIT]      = ready_q;          // [RQ3]
	end

	always_comb begin
		motor_d = motor_q;
		if (param_update) begin
			motor_d = RESET_VALUE;
			motor_d[RESISTANCE_LSB +: 8] = motor_resistance;  // [RQ4]
			motor_d[EMF_CONST_LSB +: 8]  = back_emf_constant; // [RQ5]
			motor_d[INDUCTANCE_LSB +: 8] = motor_inductance;  // [RQ6]
		end
	end

	always_comb begin
		meas_d = RESET_VALUE;
		meas_d[R_STATUS_BIT]          = resistance_meas_status;  // [RQ7]
		meas_d[L_STATUS_BIT]          = inductance_meas_status;  // [RQ7]
		meas_d[KE_STATUS_BIT]         = emf_const_meas_status;   // [RQ7]
		meas_d[MECH_STATUS_BIT]       = mechanical_meas_status;  // [RQ7]
		meas_d[SWITCH_FREQ_LSB +: 4]  = recommended_switch_freq; // [RQ8]
	end

	// no write path exists into any status register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			algo_q  <= RESET_VALUE; // [RQ9]
			motor_q <= RESET_VALUE; // [RQ9]
			meas_q  <= RESET_VALUE; // [RQ9]
		end else begin
			algo_q  <= algo_d;  // [RQ11]
			motor_q <= motor_d; // [RQ11]
			meas_q  <= meas_d;  // [RQ11]
		end
	end

	// unmapped and control offsets read zero
	assign rd_mux = (bus.sel == SEL_ALGO)  ? algo_q  :
	                (bus.sel == SEL_MOTOR) ? motor_q :
	                (bus.sel == SEL_MEAS)  ? meas_q  : RESET_VALUE; // [RQ10]
	assign rd_data_d = bus.hit ? rd_mux : RESET_VALUE;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q  <= RESET_VALUE;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= reg_rd_en;
		end
	end

	assign reg_rd_data  = rd_data_q;
	assign reg_rd_valid = rd_valid_q;
endmodule : motor_algorithm_status_word_registers

/* tb/status_host_model.sv */
module status_host_model (
	input  wire logic        clock,       // system clock
	output logic      [7:0]  reg_addr,    // offset
	output logic             reg_rd_en,   // read strobe
	output logic             reg_wr_en,   // write strobe
	output logic      [31:0] reg_wr_data  // write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, reg_rd_en, reg_wr_en, reg_wr_data} = '0;
	// writes aim only at listed offsets; idle address shows the inverse of the last one
	task access(input logic [7:0] a, input logic w);
		@(negedge clock);
		{reg_addr, reg_rd_en, reg_wr_en, reg_wr_data} <= {a, !w, w, 32'hFFFFFFFF};
		@(negedge clock);
		{reg_addr, reg_rd_en, reg_wr_en, reg_wr_data} <= {~a, 2'h0, 32'h0};
	endtask : access
endmodule : status_host_model

/* tb/motor_algorithm_status_word_checker_sva.sv */
module motor_algorithm_status_word_checker (
	input wire logic        clock, reset_n, reg_rd_en, reg_wr_en, reg_rd_valid, shadow_copy_done, param_update,
	input wire logic        resistance_meas_status, inductance_meas_status, emf_const_meas_status,
	input wire logic        mechanical_meas_status,
	input wire logic [7:0]  reg_addr, motor_resistance, back_emf_constant, motor_inductance,
	input wire logic [31:0] reg_rd_data,
	input wire logic [15:0] modulation_index,
	input wire logic [11:0] duty_command,
	input wire logic [3:0]  recommended_switch_freq
);
	logic [27:0] sw_q;
	logic [23:0] mp_q;
	logic [7:0]  ms_q;
	logic        rdy_q;
	wire rd_st = reg_rd_en && reg_addr == 8'hE4;
	wire rd_mp = reg_rd_en && reg_addr == 8'hE6;
	wire rd_ms = reg_rd_en && reg_addr == 8'hE8;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) {sw_q, mp_q, ms_q, rdy_q} <= '0;
		else begin
			sw_q  <= {modulation_index, duty_command};
			ms_q  <= {resistance_meas_status, inductance_meas_status, emf_const_meas_status,
				mechanical_meas_status, recommended_switch_freq};
			rdy_q <= rdy_q | shadow_copy_done;
			if (param_update) mp_q <= {motor_resistance, back_emf_constant, motor_inductance};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_mod_index_field: assert property (rd_st |=> reg_rd_data[31:16] == $past(sw_q[27:12]))
		else $error("modulation index field wrong");
	a_duty_cmd_field: assert property (rd_st |=> reg_rd_data[15:4] == $past(sw_q[11:0]))
		else $error("duty command field wrong");
	a_host_ready_flag: assert property (rd_st |=> reg_rd_data[2] == $past(rdy_q, 2))
		else $error("ready flag wrong");
	a_status_spare_zero: assert property (rd_st |=> reg_rd_valid && {reg_rd_data[3], reg_rd_data[1:0]} == 3'h0)
		else $error("status word spare bits set");
	a_motor_param_word: assert property (rd_mp |=> reg_rd_data == {$past(mp_q), 8'h00})
		else $error("motor parameter word wrong");
	a_meas_status_word: assert property (rd_ms |=> reg_rd_data == {$past(ms_q), 24'h000000})
		else $error("measurement status word wrong");
	a_unmapped_read_zero: assert property (reg_rd_en && !(reg_addr inside {8'hE4, 8'hE6, 8'hE8})
		|=> reg_rd_valid && reg_rd_data == 32'h00000000)
		else $error("unmapped read not zero");
	a_write_no_answer: assert property (reg_wr_en && !reg_rd_en |=> !reg_rd_valid && reg_rd_data == 32'h0)
		else $error("write produced an answer");
	c_read_status: cover property (rd_st);
	c_read_params: cover property (rd_mp);
	c_read_meas: cover property (rd_ms);
endmodule : motor_algorithm_status_word_checker
bind motor_algorithm_status_word_registers motor_algorithm_status_word_checker i_motor_algorithm_status_word_checker (.*);

/* tb/motor_algorithm_status_word_registers_tb_top.sv */
module motor_algorithm_status_word_registers_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] mi; logic [11:0] dc; logic sd; logic [23:0] mp; logic [7:0] ms;
		logic [31:0] e4, e6, e8;
	} row_t;
	logic clock, reset_n, reg_rd_en, reg_wr_en, reg_rd_valid, shadow_copy_done, param_update;
	logic resistance_meas_status, inductance_meas_status, emf_const_meas_status, mechanical_meas_status;
	logic [7:0] reg_addr, motor_resistance, back_emf_constant, motor_inductance;
	logic [31:0] reg_wr_data, reg_rd_data;
	logic [15:0] modulation_index;
	logic [11:0] duty_command;
	logic [3:0] recommended_switch_freq;
	int bad_count, check_count;
	row_t rows [3] = '{
		'{16'h8000, 12'hFFF, 1'b0, 24'h123456, 8'hA5, 32'h8000FFF0, 32'h12345600, 32'hA5000000},
		'{16'h0001, 12'h001, 1'b1, 24'hFEDCBA, 8'h5F, 32'h00010014, 32'hFEDCBA00, 32'h5F000000},
		'{16'hFFFF, 12'h800, 1'b0, 24'h000000, 8'h0A, 32'hFFFF8004, 32'h00000000, 32'h0A000000}};
	motor_algorithm_status_word_registers i_motor_algorithm_status_word_registers (.*);
	status_host_model i_status_host_model (.*);
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED valid_and_data expected %h seen %h", exp, seen);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [31:0] e);
		// access returns at the falling edge after the taking edge, while the answer stands
		i_status_host_model.access(a, 1'b0);
		chk({reg_rd_valid, reg_rd_data}, {1'b1, e});
	endtask : rd
	task results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	initial begin
		#30000 bad_count++;
		results;
	end
	initial begin
		{reset_n, shadow_copy_done, param_update, modulation_index, duty_command} = '0;
		{motor_resistance, back_emf_constant, motor_inductance} = '0;
		{resistance_meas_status, inductance_meas_status, emf_const_meas_status} = '0;
		{mechanical_meas_status, recommended_switch_freq} = '0;
		repeat (2) @(negedge clock);
		reset_n = 1;
		rd(8'hE6, 32'h0);
		rd(8'hEA, 32'h0);
		foreach (rows[i]) begin
			@(negedge clock);
			{modulation_index, duty_command, shadow_copy_done} = {rows[i].mi, rows[i].dc, rows[i].sd};
			{motor_resistance, back_emf_constant, motor_inductance} = rows[i].mp;
			{resistance_meas_status, inductance_meas_status, emf_const_meas_status,
				mechanical_meas_status, recommended_switch_freq} = rows[i].ms;
			param_update = 1;
			@(negedge clock);
			param_update = 0;
			rd(8'hE4, rows[i].e4);
			rd(8'hE6, rows[i].e6);
			rd(8'hE8, rows[i].e8);
		end
		// writes must leave the E6 and E4 status words as they were
		foreach (rows[i]) i_status_host_model.access(8'hE4 + 8'h02 * i[7:0], 1'b1);
		rd(8'hE6, rows[2].e6);
		rd(8'hE4, rows[2].e4);
		// reset in mid-run clears the sticky ready bit and the held motor parameters
		@(negedge clock);
		reset_n = 0;
		@(negedge clock);
		reset_n = 1;
		rd(8'hE4, 32'hFFFF8000);
		rd(8'hE6, 32'h0);
		rd(8'hE8, rows[2].e8);
		results;
	end
endmodule : motor_algorithm_status_word_registers_tb_top
